// ### design/shlm_link_master.sv
`timescale 1ns/10ps
// Contract
// RQ1 - Line rate 4800 to 115200, 9600 default
// RQ2 - Seven or eight data bits, eight default
// RQ3 - Resend on timeout up to retry count
// RQ4 - Retries exhausted: abandon, flag timeout
// RQ5 - Response timeout 1 to 30 s, 3 default
// RQ6 - Station number 1 to 31, default 1
// RQ7 - Delay 0 to 300 ms before requests
// RQ8 - Most recent configuration write wins
// RQ9 - Controller must use same line rate
// RQ10 - Controller port set to computer link
// RQ11 - One stop bit, odd parity, checked
// RQ12 - No modem handshake lines are used
module shlm_link_master #(
  parameter int CLK_HZ = shlm_pkg::CLK_HZ_DEF,
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Avalon-MM slave
  input wire logic [2:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Setup utility port
  input wire logic util_cfg_wr,
  input wire logic [31:0] util_cfg,
  // Serial line
  output logic txd,
  input wire logic rxd,
  // Interrupt
  output logic irq
);
  import shlm_pkg::*;

  // ------------------------------------------------------------
  // Derived timing
  // ------------------------------------------------------------
  localparam int CYC_PER_MS = (CLK_HZ / MS_PER_S < 1) ? 1 : CLK_HZ / MS_PER_S;
  localparam int PRE_W = $clog2(CYC_PER_MS + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(CYC_PER_MS - 1);
  localparam logic [9:0] MS_LAST = 10'(MS_PER_S - 1);

  typedef struct packed {
    shlm_cfg_t cfg;
    logic [7:0] req_chr;
    logic [7:0] rx_chr;
    shlm_evt_t sts;
    shlm_evt_t msk;
    shlm_state_t st;
    logic [3:0] tries;
    logic [PRE_W-1:0] pre;
    logic [9:0] ms;
    logic [4:0] sec;
    logic sent;
    logic txgo;
    logic ack;
    logic [31:0] rdat;
    logic irq;
  } shlm_st_t;

  shlm_st_t q;
  shlm_st_t n;
  shlm_evt_t set;
  shlm_evt_t clr;
  logic req;
  logic wr_acc;
  logic cfg_wr;
  logic req_wr;
  logic tick;
  logic tmo_hit;
  logic [31:0] rd_mux;
  logic [2:0] baud_eff;
  logic [4:0] tmo_eff;
  logic [8:0] dly_eff;
  logic [4:0] stn_eff;
  logic [DIV_W-1:0] div_tab [NUM_BAUD];
  logic [DIV_W-1:0] bit_div;
  logic [7:0] tx_data;
  logic tx_busy;
  logic rx_valid;
  logic [7:0] rx_data;
  logic rx_err;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = be[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  // ------------------------------------------------------------
  // Line rate table
  // ------------------------------------------------------------
  // Constant divisors, one per selectable rate, so no runtime divider
  for (genvar i = 0; i < NUM_BAUD; i++) begin : g_div
    assign div_tab[i] = DIV_W'(CLK_HZ / BAUD_RATE[i]); // [RQ1]
  end

  // Out-of-range settings fall back to safe values rather than stalling
  always_comb begin
    baud_eff = (q.cfg.baud > BAUD_SEL_MAX) ? BAUD_SEL_DEF : q.cfg.baud; // [RQ1]
    tmo_eff = q.cfg.tmo_s; // [RQ5]
    if (q.cfg.tmo_s < TMO_MIN_S) begin
      tmo_eff = TMO_MIN_S;
    end else if (q.cfg.tmo_s > TMO_MAX_S) begin
      tmo_eff = TMO_MAX_S;
    end
    dly_eff = (q.cfg.dly_ms > DLY_MAX_MS) ? DLY_MAX_MS : q.cfg.dly_ms; // [RQ7]
    stn_eff = (q.cfg.stn < STN_MIN) ? STN_MIN : q.cfg.stn; // [RQ6]
  end

  assign bit_div = div_tab[baud_eff];
  assign tx_data = (q.st == ST_TXST) ? {3'h0, stn_eff} : q.req_chr; // [RQ6]

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // One wait state: readdata is captured before the releasing edge
  assign req = avs_read | avs_write;
  assign avs_waitrequest = req & ~q.ack;
  assign wr_acc = q.ack & avs_write;
  assign cfg_wr = wr_acc && avs_address == REG_CFG;
  assign req_wr = wr_acc && avs_address == REG_REQ;
  assign avs_readdata = q.rdat;
  assign irq = q.irq;
  assign tick = q.pre == PRE_LAST;
  assign tmo_hit = q.sec >= tmo_eff; // [RQ5]

  // Read multiplexer; unmapped words read as zero
  always_comb begin
    unique case (avs_address)
      REG_CFG: rd_mux = q.cfg;
      REG_REQ: rd_mux = {24'h0, q.req_chr};
      REG_RX: rd_mux = {24'h0, q.rx_chr};
      REG_STAT: rd_mux = 32'(q.sts);
      REG_MASK: rd_mux = 32'(q.msk);
      REG_INFO: rd_mux = 32'({q.tries, q.st});
      default: rd_mux = '0;
    endcase
  end

  // ------------------------------------------------------------
  // Request sequencer
  // ------------------------------------------------------------
  // Flow is only request, response, timeout; no modem line gates it [RQ12]
  always_comb begin
    n = q;
    set = '0;
    clr = '0;
    n.txgo = 1'h0;
    n.ack = req & ~q.ack;
    if (req && !q.ack) begin
      n.rdat = rd_mux;
    end
    // Bus write and utility load share one register, so the last one stands
    if (cfg_wr) begin
      n.cfg = shlm_cfg_t'(merge(q.cfg, avs_writedata, avs_byteenable)); // [RQ8]
    end else if (util_cfg_wr) begin
      n.cfg = shlm_cfg_t'(util_cfg); // [RQ8]
    end
    if (wr_acc && avs_address == REG_MASK && avs_byteenable[0]) begin
      n.msk = shlm_evt_t'(avs_writedata[EVT_W-1:0]);
    end
    if (wr_acc && avs_address == REG_STAT && avs_byteenable[0]) begin
      clr = shlm_evt_t'(avs_writedata[EVT_W-1:0]);
    end
    n.pre = tick ? '0 : q.pre + 1'h1;
    unique case (q.st)
      ST_IDLE: begin
        if (req_wr) begin // [RQ12]
          n.req_chr = avs_writedata[7:0];
          n.tries = '0;
          n.st = ST_DLY;
          n.ms = '0;
          n.pre = '0;
        end
      end
      ST_DLY: begin
        if (q.ms >= 10'(dly_eff)) begin // [RQ7]
          n.st = q.cfg.stmode ? ST_TXST : ST_TXDT; // [RQ6]
        end else if (tick) begin
          n.ms = q.ms + 10'h001;
        end
      end
      ST_TXST, ST_TXDT: begin
        if (!q.sent) begin
          n.txgo = 1'h1;
          n.sent = 1'h1;
        end else if (!q.txgo && !tx_busy) begin
          n.sent = 1'h0;
          n.st = (q.st == ST_TXST) ? ST_TXDT : ST_WAIT;
          n.ms = '0;
          n.sec = '0;
          n.pre = '0;
        end
      end
      ST_WAIT: begin
        // A response in the timeout cycle still counts as answered
        if (rx_valid) begin
          n.rx_chr = rx_data;
          set.done = 1'h1;
          set.perr = rx_err; // [RQ11]
          n.st = ST_IDLE;
        end else if (tmo_hit) begin
          if (q.tries < q.cfg.retry) begin // [RQ3]
            n.tries = q.tries + 4'h1;
            set.rtry = 1'h1;
            n.st = ST_DLY;
            n.ms = '0;
            n.pre = '0;
          end else begin
            set.tmo = 1'h1; // [RQ4]
            n.st = ST_IDLE;
          end
        end else if (tick) begin
          if (q.ms == MS_LAST) begin
            n.ms = '0;
            n.sec = q.sec + 5'h01; // [RQ5]
          end else begin
            n.ms = q.ms + 10'h001;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase
    // Set beats clear so no event is lost to a racing acknowledge
    n.sts = (q.sts & ~clr) | set;
    n.irq = |(n.sts & n.msk);
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
      q.cfg <= CFG_RST; // [RQ1] [RQ2]
    end else begin
      q <= n;
    end
  end

  // ------------------------------------------------------------
  // Serial engine
  // ------------------------------------------------------------
  shlm_uart_phy #(
    .DIV_W(DIV_W)
  ) u_phy (
    .ref_clk(ref_clk),
    .reset(reset),
    .bit_div(bit_div),
    .seven(q.cfg.seven), // [RQ2]
    .tx_start(q.txgo),
    .tx_data(tx_data),
    .tx_busy(tx_busy),
    .txd(txd),
    .rxd(rxd),
    .rx_valid(rx_valid),
    .rx_data(rx_data),
    .rx_err(rx_err)
  );

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  AST_CFG_RST: assert property ($fell(reset) && !util_cfg_wr |-> // [RQ1]
    q.cfg == CFG_RST ##1 bit_div == div_tab[BAUD_SEL_DEF])
    else $error("line rate not at default after reset");
  AST_BAUD_CLAMP: assert property (q.cfg.baud > BAUD_SEL_MAX |-> // [RQ1]
    bit_div == div_tab[BAUD_SEL_DEF])
    else $error("illegal rate code not mapped to default");
  AST_RETRY: assert property ((q.st == ST_WAIT && tmo_hit && !rx_valid && // [RQ3]
    q.tries < q.cfg.retry) |=> q.st == ST_DLY && q.tries == $past(q.tries) + 4'h1
    && q.sts.rtry)
    else $error("retry not issued after timeout");
  AST_GIVEUP: assert property ((q.st == ST_WAIT && tmo_hit && !rx_valid && // [RQ4]
    q.tries >= q.cfg.retry) |=> q.st == ST_IDLE && q.sts.tmo)
    else $error("exhausted request not abandoned");
  AST_TMO: assert property ($rose(q.sts.tmo) |-> // [RQ5]
    $past(q.sec) >= $past(tmo_eff) && $past(q.st) == ST_WAIT)
    else $error("timeout raised before period elapsed");
  AST_STN: assert property ((q.txgo && q.st == ST_TXST) |-> // [RQ6]
    tx_data >= {3'h0, STN_MIN} && tx_data[7:5] == 3'h0)
    else $error("station number out of range");
  AST_DELAY: assert property ((q.st == ST_DLY && q.ms < 10'(dly_eff)) |=> // [RQ7]
    q.st == ST_DLY && !q.txgo)
    else $error("request sent before delay elapsed");
  AST_LATEST: assert property ((util_cfg_wr && !cfg_wr) |=> // [RQ8]
    q.cfg == $past(util_cfg))
    else $error("utility setting not applied");
  // A zero delay bounds the start; longer delays are covered by AST_DELAY
  AST_NO_HS: assert property ((q.st == ST_IDLE && req_wr && dly_eff == '0) |=> // [RQ12]
    q.st == ST_DLY ##[1:3] q.txgo)
    else $error("request not started");

  COV_DONE: cover property (q.st == ST_WAIT ##1 q.sts.done);
  COV_RETRY: cover property ($rose(q.sts.rtry));
  COV_TMO: cover property ($rose(q.sts.tmo));

endmodule

// ### design/shlm_pkg.sv
package shlm_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int CLK_HZ_DEF = 20_000_000;
  localparam int MS_PER_S = 1000;
  localparam int NUM_BAUD = 6;
  localparam int BAUD_RATE [NUM_BAUD] = '{4800, 9600, 19200, 38400, 57600, 115200};
  localparam logic [2:0] BAUD_SEL_DEF = 3'h1;
  localparam logic [2:0] BAUD_SEL_MAX = 3'h5;
  localparam logic [4:0] TMO_MIN_S = 5'h01;
  localparam logic [4:0] TMO_MAX_S = 5'h1E;
  localparam logic [4:0] TMO_DEF_S = 5'h03;
  localparam logic [8:0] DLY_MAX_MS = 9'h12C;
  localparam logic [8:0] DLY_DEF_MS = 9'h000;
  localparam logic [4:0] STN_MIN = 5'h01;
  localparam logic [4:0] STN_DEF = 5'h01;
  localparam logic [3:0] RETRY_DEF = 4'h0;

  // ------------------------------------------------------------
  // Character framing
  // ------------------------------------------------------------
  localparam logic [3:0] DATA_BITS8 = 4'h8;
  localparam logic [3:0] DATA_BITS7 = 4'h7;
  localparam logic [3:0] FRM_EXTRA = 4'h3;

  // ------------------------------------------------------------
  // Register map, word index on the bus
  // ------------------------------------------------------------
  localparam logic [2:0] REG_CFG = 3'h0;
  localparam logic [2:0] REG_REQ = 3'h1;
  localparam logic [2:0] REG_RX = 3'h2;
  localparam logic [2:0] REG_STAT = 3'h3;
  localparam logic [2:0] REG_MASK = 3'h4;
  localparam logic [2:0] REG_INFO = 3'h5;

  typedef struct packed {
    logic [3:0] rsv;
    logic [8:0] dly_ms;
    logic [4:0] tmo_s;
    logic [3:0] retry;
    logic [4:0] stn;
    logic stmode;
    logic seven;
    logic [2:0] baud;
  } shlm_cfg_t;

  localparam shlm_cfg_t CFG_RST = '{rsv: 4'h0, dly_ms: DLY_DEF_MS, tmo_s: TMO_DEF_S,
    retry: RETRY_DEF, stn: STN_DEF, stmode: 1'h1, seven: 1'h0, baud: BAUD_SEL_DEF};

  typedef struct packed {
    logic rtry;
    logic perr;
    logic tmo;
    logic done;
  } shlm_evt_t;

  localparam int EVT_W = $bits(shlm_evt_t);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_DLY = 3'h1,
    ST_TXST = 3'h3,
    ST_TXDT = 3'h2,
    ST_WAIT = 3'h6
  } shlm_state_t;

endpackage

// ### design/shlm_uart_phy.sv
`timescale 1ns/10ps
module shlm_uart_phy #(
  parameter int DIV_W = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // Line settings
  input wire logic [DIV_W-1:0] bit_div,
  input wire logic seven,
  // Transmit side
  input wire logic tx_start,
  input wire logic [7:0] tx_data,
  output logic tx_busy,
  output logic txd,
  // Receive side
  input wire logic rxd,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_err
);
  import shlm_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] tcnt;
    logic [3:0] tbit;
    logic [10:0] tsh;
    logic tbusy;
    logic s1;
    logic s2;
    logic [DIV_W-1:0] rcnt;
    logic [3:0] rbit;
    logic [10:0] rsh;
    logic rbusy;
    logic rvalid;
    logic [7:0] rdata;
    logic rerr;
  } shlm_phy_st_t;

  shlm_phy_st_t q;
  shlm_phy_st_t n;
  logic [3:0] nbits;
  logic par;
  logic [7:0] d;
  logic p;

  assign tx_busy = q.tbusy;
  assign txd = q.tsh[0];
  assign rx_valid = q.rvalid;
  assign rx_data = q.rdata;
  assign rx_err = q.rerr;

  // ------------------------------------------------------------
  // Bit engine
  // ------------------------------------------------------------
  // Start, data, odd parity, one stop; the shifter idles all ones
  always_comb begin
    n = q;
    n.s1 = rxd;
    n.s2 = q.s1;
    n.rvalid = 1'h0;
    nbits = (seven ? DATA_BITS7 : DATA_BITS8) + FRM_EXTRA;
    par = ~(^(seven ? {1'h0, tx_data[6:0]} : tx_data)); // [RQ11]
    d = '0;
    p = 1'h0;
    if (!q.tbusy) begin
      if (tx_start) begin
        n.tsh = seven ? {2'h3, par, tx_data[6:0], 1'h0} : {1'h1, par, tx_data, 1'h0};
        n.tbusy = 1'h1;
        n.tbit = nbits;
        n.tcnt = '0;
      end
    end else if (q.tcnt == bit_div - 1'h1) begin
      n.tcnt = '0;
      n.tsh = {1'h1, q.tsh[10:1]};
      n.tbit = q.tbit - 4'h1;
      if (q.tbit == 4'h1) begin
        n.tbusy = 1'h0;
      end
    end else begin
      n.tcnt = q.tcnt + 1'h1;
    end
    // Receiver samples mid-bit, counting from half a bit after the edge
    if (!q.rbusy) begin
      if (!q.s2) begin
        n.rbusy = 1'h1;
        n.rcnt = bit_div >> 1;
        n.rbit = '0;
      end
    end else if (q.rcnt == bit_div - 1'h1) begin
      n.rcnt = '0;
      n.rsh[q.rbit] = q.s2;
      n.rbit = q.rbit + 4'h1;
      if (q.rbit == '0 && q.s2) begin
        n.rbusy = 1'h0; // Glitch, not a start bit
      end else if (q.rbit == nbits - 4'h1) begin
        d = seven ? {1'h0, n.rsh[7:1]} : n.rsh[8:1];
        p = seven ? n.rsh[8] : n.rsh[9];
        n.rdata = d;
        n.rerr = ~(^{d, p}) | ~q.s2; // [RQ11]
        n.rvalid = 1'h1;
        n.rbusy = 1'h0;
      end
    end else begin
      n.rcnt = q.rcnt + 1'h1;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      q <= '0;
      q.tsh <= '1;
      q.s1 <= 1'h1;
      q.s2 <= 1'h1;
    end else begin
      q <= n;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  AST_START_BIT: assert property (@(posedge ref_clk) disable iff (reset) // [RQ11]
    (tx_start && !tx_busy) |=> (!txd && tx_busy) [*2])
    else $error("start bit not driven low");
  AST_RX7: assert property (@(posedge ref_clk) disable iff (reset) // [RQ2]
    (rx_valid && seven) |-> !rx_data[7])
    else $error("seven bit character has bit 7 set");

endmodule

// ### test/shlm_ctrl_model.sv
`timescale 1ns/10ps
// Controller serial port at the far end of the line, behavioural
module shlm_ctrl_model (
  // Clock and line
  input wire logic ref_clk,
  input wire logic txd,
  output logic rxd,
  // Settings from the bench
  input int bit_cyc,
  input wire logic seven,
  input int n_req,
  input int base,
  input wire logic reply_en,
  input wire logic bad_par,
  input wire logic [7:0] reply,
  // What was heard
  output logic [7:0] last_ch,
  output logic [7:0] prev_ch,
  output int n_got,
  output logic frm_ok
);
  logic [7:0] c;
  logic p;

  initial begin
    rxd = 1'b1;
    n_got = 0;
    frm_ok = 1'b1;
    last_ch = 8'h00;
    prev_ch = 8'h00;
  end

  // Answer frame; bad parity only when the bench asks for it
  task automatic send(input logic [7:0] d);
    rxd <= 1'b0;
    repeat (bit_cyc) @(posedge ref_clk);
    for (int i = 0; i < (seven ? 7 : 8); i++) begin
      rxd <= d[i];
      repeat (bit_cyc) @(posedge ref_clk);
    end
    rxd <= ~(seven ? ^d[6:0] : ^d) ^ bad_par;
    repeat (bit_cyc) @(posedge ref_clk);
    rxd <= 1'b1;
    repeat (bit_cyc) @(posedge ref_clk);
  endtask

  // Sample mid-bit at the bench's rate; a rate mismatch garbles chars
  // Only the data line is watched, no handshake lines exist
  always begin
    @(negedge txd);
    c = 8'h00;
    p = 1'b0;
    repeat (bit_cyc / 2) @(posedge ref_clk);
    for (int i = 0; i < (seven ? 7 : 8); i++) begin
      repeat (bit_cyc) @(posedge ref_clk);
      c[i] = txd;
      p = p ^ txd;
    end
    repeat (bit_cyc) @(posedge ref_clk);
    // Odd parity, then exactly one stop bit
    if ((p ^ txd) !== 1'b1) frm_ok = 1'b0;
    repeat (bit_cyc) @(posedge ref_clk);
    if (txd !== 1'b1) frm_ok = 1'b0;
    prev_ch = last_ch;
    last_ch = c;
    n_got++;
    // Reply once the whole request is in; silence models a dead controller
    if (reply_en && n_got == base + n_req) begin
      repeat (bit_cyc * 2) @(posedge ref_clk);
      send(reply);
    end
  end
endmodule

// ### test/tb_serial_host_link_master.sv
`timescale 1ns/10ps
module tb_serial_host_link_master;
  import shlm_pkg::*;
  // Small clock so a whole second fits; only 4800 and 9600 keep a sane divisor
  localparam int CLK_HZ = 38400;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int CYC_MAX = 99000;
  logic ref_clk = 1'b0;
  logic reset, avs_read, avs_write, avs_waitrequest, util_cfg_wr, txd, rxd, irq;
  logic [2:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, util_cfg, q;
  logic m_seven, reply_en, bad_par;
  logic [7:0] reply, last_ch, prev_ch;
  int bit_cyc, n_req, base, n_got, cyc, n_mismatch, n_tests;
  logic frm_ok;

  shlm_link_master #(.CLK_HZ(CLK_HZ)) shlm_link_master_i (.ref_clk(ref_clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .util_cfg_wr(util_cfg_wr), .util_cfg(util_cfg),
    .txd(txd), .rxd(rxd), .irq(irq));
  shlm_ctrl_model shlm_ctrl_model_i (.ref_clk(ref_clk), .txd(txd), .rxd(rxd),
    .bit_cyc(bit_cyc), .seven(m_seven), .n_req(n_req), .base(base), .reply_en(reply_en),
    .bad_par(bad_par), .reply(reply), .last_ch(last_ch), .prev_ch(prev_ch), .n_got(n_got),
    .frm_ok(frm_ok));

  // ----------------------------------------------------------
  // Clock, hang guard, reporting
  // ----------------------------------------------------------
  always #25 ref_clk = ~ref_clk;

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == CYC_MAX) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("counts: %0d checks, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ----------------------------------------------------------
  // Bus and wait helpers; entered and left just after a rising edge
  // ----------------------------------------------------------
  // Waitrequest and readdata are read at the rising edge, before that edge's updates land
  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    n = 0;
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 50) chk("waitrequest", 32'h0, 32'h1);
    @(posedge ref_clk);
  endtask

  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (s !== v && n < lim);
  endtask

  function automatic shlm_cfg_t mk(input int b, sv, sm, st, rt, tm, dl);
    shlm_cfg_t r;
    r = '{rsv: 4'h0, dly_ms: 9'(dl), tmo_s: 5'(tm), retry: 4'(rt), stn: 5'(st),
      stmode: 1'(sm), seven: 1'(sv), baud: 3'(b)};
    return r;
  endfunction

  // One request from configuration to cleared interrupt
  task automatic run_req(input string name, input shlm_cfg_t c, input logic [7:0] ch,
    input logic rep, input logic bp, input logic [3:0] msk, input logic [3:0] exp_st);
    logic [7:0] m;
    int n, d, w;
    m = c.seven ? 8'h7F : 8'hFF;
    d = (c.dly_ms > 300) ? 300 : c.dly_ms;
    // A second is a thousand whole-cycle milliseconds, so it falls short of CLK_HZ
    w = 2 * c.tmo_s * 1000 * MS_CYC;
    bus(1'b1, REG_CFG, c, q);
    bus(1'b1, REG_STAT, 32'h0000_000F, q);
    bus(1'b1, REG_MASK, {28'h0, msk}, q);
    bit_cyc <= CLK_HZ / BAUD_RATE[c.baud];
    m_seven <= c.seven;
    n_req <= c.stmode ? 2 : 1;
    reply_en <= rep;
    bad_par <= bp;
    reply <= 8'($urandom);
    base <= n_got;
    bus(1'b1, REG_REQ, {24'h0, ch}, q);
    wait_lvl(txd, 1'b0, 20000, n);
    chk("delay low", 32'h1, 32'(n + MS_CYC >= d * MS_CYC));
    chk("delay high", 32'h1, 32'(n <= d * MS_CYC + 8));
    wait_lvl(irq, 1'b1, rep ? 4000 : w + 4000, n);
    bus(1'b0, REG_STAT, 32'h0, q);
    chk("status", {28'h0, exp_st}, q);
    if (rep) begin
      chk("request char", {24'h0, ch & m}, {24'h0, last_ch});
      if (c.stmode) chk("station char", {27'h0, c.stn}, {24'h0, prev_ch});
      bus(1'b0, REG_RX, 32'h0, q);
      chk("response", {24'h0, reply & m}, q);
    end else begin
      chk("sends", 32'(2 * n_req), 32'(n_got - base));
      chk("timeout low", 32'h1, 32'(n >= w));
      chk("timeout high", 32'h1, 32'(n <= w + 2000));
    end
    chk("tx framing", 32'h1, {31'h0, frm_ok});
    bus(1'b1, REG_STAT, 32'h0000_000F, q);
    bus(1'b0, REG_STAT, 32'h0, q);
    chk("status cleared", 32'h0, q);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test %s done", name);
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    {avs_read, avs_write, util_cfg_wr, reply_en, bad_par, m_seven} = 6'h00;
    {avs_address, avs_writedata, util_cfg, reply} = '0;
    bit_cyc = 4;
    n_req = 2;
    base = 0;
    cyc = 0;
    n_mismatch = 0;
    n_tests = 0;
    reset = 1'b1;
    void'($urandom(32'h2A5D));
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    bus(1'b0, REG_CFG, 32'h0, q);
    chk("cfg reset", mk(1, 0, 1, 1, 0, 3, 0), q);
    bus(1'b1, 3'h7, 32'hFFFF_FFFF, q);
    bus(1'b0, 3'h7, 32'h0, q);
    chk("unmapped", 32'h0, q);
    $display("test reset done");
    run_req("defaults", mk(1, 0, 1, 1, 0, 3, 0), 8'($urandom), 1, 0, 4'h1, 4'h1);
    // Both usable rates against both char lengths, random station and delay
    for (int i = 0; i < 4; i++) begin
      run_req("rate_len", mk(i % 2, i / 2, 1, 1 + $urandom % 31, 0, 3, $urandom % 4),
        8'($urandom), 1, 0, 4'h1, 4'h1);
    end
    run_req("station 31", mk(0, 1, 1, 31, 0, 3, 1), 8'($urandom), 1, 0, 4'h1, 4'h1);
    run_req("bad parity", mk(1, 0, 0, 5, 0, 3, 0), 8'($urandom), 1, 1, 4'h1, 4'h5);
    run_req("delay clamp", mk(1, 0, 0, 1, 0, 3, 511), 8'($urandom), 1, 0, 4'h1, 4'h1);
    // Two setting sources: whichever wrote last is in force
    for (int i = 0; i < 3; i++) begin
      q = mk(i % 2, 1, 0, 1 + i, i, 4 + i, 7 * i);
      if (i == 1) begin
        bus(1'b1, REG_CFG, q, q);
      end else begin
        util_cfg <= q;
        util_cfg_wr <= 1'b1;
        @(posedge ref_clk);
        util_cfg_wr <= 1'b0;
        @(posedge ref_clk);
      end
      bus(1'b0, REG_CFG, 32'h0, q);
      chk("latest setting", mk(i % 2, 1, 0, 1 + i, i, 4 + i, 7 * i), q);
    end
    $display("test sources done");
    // No answer at all: one resend, then give up; only the timeout event unmasked
    run_req("timeout", mk(1, 0, 0, 1, 1, 1, 0), 8'($urandom), 0, 0, 4'h2, 4'hA);
    give_verdict();
  end
endmodule
